/* core/rrse_pkg.sv */
// Purpose: Shared constants and types for the return/rotate/subtract executor
// Assumes: One 40 MHz core clock, one instruction per cycle at most
// Notes:   Register offsets index the plain register port
package rrse_pkg;

    localparam int          CLK_PERIOD_NS = 25;
    localparam int          RET_CYCLES    = 2;

    // Register port map
    localparam int          REG_ADDR_W    = 3;
    localparam logic [2:0]  REG_CTRL      = 3'h0;
    localparam logic [2:0]  REG_FLAGS     = 3'h1;
    localparam logic [2:0]  REG_WREG      = 3'h2;
    localparam logic [2:0]  REG_PC_LO     = 3'h3;
    localparam logic [2:0]  REG_PC_HI     = 3'h4;
    localparam logic [2:0]  REG_LEVEL     = 3'h5;

    // Field positions
    localparam int          CTRL_EN_BIT   = 0;
    localparam int          FLAG_C_BIT    = 0;
    localparam int          FLAG_DC_BIT   = 1;
    localparam int          FLAG_Z_BIT    = 2;
    localparam int          FLAG_GIE_BIT  = 3;

    // Values after reset
    localparam logic [7:0]  CTRL_RST      = 8'h01;
    localparam logic [7:0]  WREG_RST      = 8'h00;
    localparam logic [3:0]  FLAGS_RST     = 4'h0;
    localparam logic [9:0]  PC_RST        = 10'h000;
    localparam logic [7:0]  RDATA_RST     = 8'h00;

    // File target select
    localparam logic        DEST_WREG     = 1'b0;
    localparam logic        DEST_FILE     = 1'b1;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_IRQ_RET,
        OP_SUB_RET,
        OP_ROT_L,
        OP_ROT_R,
        OP_REG_SBC,
        OP_IMM_SBC,
        OP_AUX_RD
    } rrse_op_t;

    typedef struct packed {
        rrse_op_t    op;
        logic [5:0]  file_addr;
        logic        to_file;
        logic [7:0]  imm;
        logic [3:0]  aux_idx;
    } rrse_instr_t;

    typedef struct packed {
        logic [2:0]  addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } rrse_bus_req_t;

    typedef struct packed {
        logic [7:0]  data;
        logic        carry;
        logic        half;
        logic        zero;
    } rrse_alu_res_t;

endpackage

/* core/rrse_alu.sv */
// Purpose: Rotate-through-carry and subtract-with-borrow datapath
// Assumes: Purely combinational, operands valid in the same cycle
// Notes:   Subtraction is an add of the inverted working register
`timescale 1ns/1ps
module rrse_alu
    import rrse_pkg::*;
(
    input  wire rrse_op_t      op_i,
    input  wire logic [7:0]    operand_i,
    input  wire logic [7:0]    wreg_i,
    input  wire logic          carry_i,
    output rrse_alu_res_t      res_o
);

    logic [8:0] sum;
    logic [4:0] low_sum;

    always_comb begin
        sum     = {1'b0, operand_i} + {1'b0, ~wreg_i} + {8'h00, carry_i}; // RULE7 RULE9
        low_sum = {1'b0, operand_i[3:0]} + {1'b0, ~wreg_i[3:0]} + {4'h0, carry_i};
        res_o   = '0;
        case (op_i)
            OP_ROT_L: begin
                res_o.data  = {operand_i[6:0], carry_i}; // RULE4
                res_o.carry = operand_i[7]; // RULE4
            end
            OP_ROT_R: begin
                res_o.data  = {carry_i, operand_i[7:1]}; // RULE5
                res_o.carry = operand_i[0]; // RULE5
            end
            OP_REG_SBC, OP_IMM_SBC: begin
                res_o.data  = sum[7:0];
                // Carry out of the add means no borrow
                res_o.carry = sum[8]; // RULE8
                res_o.half  = low_sum[4]; // RULE7
                res_o.zero  = (sum[7:0] == 8'h00); // RULE8
            end
            default: begin
                res_o = '0;
            end
        endcase
    end

endmodule

/* core/rrse_exec.sv */
// Purpose: Executes returns, rotates, subtract-with-borrow and aux-page reads
// Assumes: Decoded instructions and file data come from logic on CORE_CLK_I
// Notes:   File and aux reads are same-cycle; file write-back lands one cycle later
//
// Functional notes
// RULE1: Interrupt return pops PC, sets permit, two cycles
// RULE2: Subroutine return pops PC, flags untouched, two cycles
// RULE3: Both returns drop stack level by one; a return on an empty stack leaves the level at zero here
// RULE4: Rotate left: carry in bit0, bit7 out
// RULE5: Rotate right: carry in bit7, bit0 out
// RULE6: Target bit picks working or file register
// RULE7: Register subtract adds inverted working plus carry
// RULE8: Carry means no borrow; zero on null result
// RULE9: Immediate subtract always writes working register
// RULE10: Aux read copies indexed register, flags kept
// RULE11: Rotates change only the carry flag
// RULE12: Return flushes the instruction fetched after it
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module rrse_exec
    import rrse_pkg::*;
#(
    parameter int STACK_DEPTH = 8
) (
    input  wire logic           CORE_CLK_I,
    input  wire logic           RST_N_I,
    input  wire rrse_bus_req_t  REG_REQ_I,
    output logic [7:0]          REG_RDATA_O,
    input  wire logic           INSTR_VALID_I,
    input  wire rrse_instr_t    INSTR_I,
    output logic                INSTR_READY_O,
    input  wire logic           PUSH_I,
    input  wire logic [9:0]     PUSH_ADDR_I,
    output logic [5:0]          FILE_ADDR_O,
    input  wire logic [7:0]     FILE_RDATA_I,
    output logic                FILE_WE_O,
    output logic [5:0]          FILE_WADDR_O,
    output logic [7:0]          FILE_WDATA_O,
    output logic [3:0]          AUX_IDX_O,
    input  wire logic [7:0]     AUX_RDATA_I,
    output logic [9:0]          PC_O,
    output logic                FLUSH_O,
    output logic [7:0]          WREG_O,
    output logic [3:0]          FLAGS_O
);

    localparam int LVL_W = $clog2(STACK_DEPTH + 1);
    localparam int IDX_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

    typedef enum logic {
        ST_EXEC,
        ST_FLUSH
    } rrse_state_t;

    function automatic logic is_return(input rrse_op_t op);
        return (op == OP_IRQ_RET) || (op == OP_SUB_RET);
    endfunction

    // Rotates and register subtract may send their result back to the file
    function automatic logic writes_file(input rrse_instr_t ins);
        return ((ins.op == OP_ROT_L) || (ins.op == OP_ROT_R) || (ins.op == OP_REG_SBC))
            && (ins.to_file == DEST_FILE);
    endfunction

    // Architectural state
    rrse_state_t  state_ff;
    rrse_state_t  nxt_state;
    logic [7:0]   ctrl_ff;
    logic [7:0]   nxt_ctrl;
    logic [7:0]   wreg_ff;
    logic [7:0]   nxt_wreg;
    logic [3:0]   flags_ff;
    logic [3:0]   nxt_flags;
    logic [9:0]   pc_ff;
    logic [9:0]   nxt_pc;
    logic [7:0]   rdata_ff;
    logic [7:0]   nxt_rdata;
    logic         fwe_ff;
    logic         nxt_fwe;
    logic [5:0]   fwaddr_ff;
    logic [5:0]   nxt_fwaddr;
    logic [7:0]   fwdata_ff;
    logic [7:0]   nxt_fwdata;

    // Return stack
    logic [9:0]       stack_ff [STACK_DEPTH];
    logic [9:0]       nxt_stack [STACK_DEPTH];
    logic [LVL_W-1:0] level_ff;
    logic [LVL_W-1:0] nxt_level;
    logic [IDX_W-1:0] top_idx;
    logic [IDX_W-1:0] push_idx;

    logic             take;
    logic             pop;
    logic [7:0]       operand;
    rrse_alu_res_t    alu_res;

    assign INSTR_READY_O = ctrl_ff[CTRL_EN_BIT] && (state_ff == ST_EXEC);
    assign take          = INSTR_VALID_I && INSTR_READY_O;
    assign pop           = take && is_return(INSTR_I.op);
    assign FILE_ADDR_O   = INSTR_I.file_addr;
    assign AUX_IDX_O     = INSTR_I.aux_idx;
    assign operand       = (INSTR_I.op == OP_IMM_SBC) ? INSTR_I.imm : FILE_RDATA_I;
    assign top_idx       = IDX_W'(level_ff - LVL_W'(1));
    assign push_idx      = IDX_W'(level_ff);

    assign REG_RDATA_O   = rdata_ff;
    assign FILE_WE_O     = fwe_ff;
    assign FILE_WADDR_O  = fwaddr_ff;
    assign FILE_WDATA_O  = fwdata_ff;
    assign PC_O          = pc_ff;
    // The slot after a return holds a stale fetch
    assign FLUSH_O       = (state_ff == ST_FLUSH); // RULE12
    assign WREG_O        = wreg_ff;
    assign FLAGS_O       = flags_ff;

    rrse_alu u_alu (
        .op_i      (INSTR_I.op),
        .operand_i (operand),
        .wreg_i    (wreg_ff),
        .carry_i   (flags_ff[FLAG_C_BIT]),
        .res_o     (alu_res)
    );

    // Execution and software register writes
    always_comb begin
        nxt_state  = state_ff;
        nxt_ctrl   = ctrl_ff;
        nxt_wreg   = wreg_ff;
        nxt_flags  = flags_ff;
        nxt_pc     = pc_ff;

        // Software writes go first so an executing instruction overrides them
        if (REG_REQ_I.wr) begin
            if (REG_REQ_I.addr == REG_CTRL) begin
                nxt_ctrl = REG_REQ_I.wdata;
            end else if (REG_REQ_I.addr == REG_FLAGS) begin
                nxt_flags = REG_REQ_I.wdata[3:0];
            end else if (REG_REQ_I.addr == REG_WREG) begin
                nxt_wreg = REG_REQ_I.wdata;
            end
        end

        case (state_ff)
            ST_EXEC: begin
                if (take) begin
                    nxt_pc = pc_ff + 10'h001;
                    case (INSTR_I.op)
                        OP_IRQ_RET, OP_SUB_RET: begin
                            nxt_pc    = stack_ff[top_idx]; // RULE1 RULE2
                            if (INSTR_I.op == OP_IRQ_RET) begin
                                nxt_flags[FLAG_GIE_BIT] = 1'b1; // RULE1
                            end
                            nxt_state = ST_FLUSH; // RULE1 RULE2
                        end
                        OP_ROT_L, OP_ROT_R, OP_REG_SBC: begin
                            nxt_flags[FLAG_C_BIT] = alu_res.carry; // RULE11
                            if (INSTR_I.op == OP_REG_SBC) begin
                                nxt_flags[FLAG_DC_BIT] = alu_res.half; // RULE7
                                nxt_flags[FLAG_Z_BIT]  = alu_res.zero; // RULE8
                            end
                            if (!writes_file(INSTR_I)) begin
                                nxt_wreg = alu_res.data; // RULE6
                            end
                        end
                        OP_IMM_SBC: begin
                            nxt_wreg               = alu_res.data; // RULE9
                            nxt_flags[FLAG_C_BIT]  = alu_res.carry; // RULE9
                            nxt_flags[FLAG_DC_BIT] = alu_res.half; // RULE9
                            nxt_flags[FLAG_Z_BIT]  = alu_res.zero; // RULE9
                        end
                        OP_AUX_RD: begin
                            nxt_wreg = AUX_RDATA_I; // RULE10
                        end
                        default: begin
                            nxt_wreg = nxt_wreg;
                        end
                    endcase
                end
            end
            ST_FLUSH: begin
                // Second return cycle: whatever is offered now is discarded
                nxt_state = ST_EXEC; // RULE12
            end
            default: begin
                nxt_state = ST_EXEC;
            end
        endcase

    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_ff  <= ST_EXEC;
            ctrl_ff   <= CTRL_RST;
            wreg_ff   <= WREG_RST;
            flags_ff  <= FLAGS_RST;
            pc_ff     <= PC_RST;
        end else begin
            state_ff  <= nxt_state;
            ctrl_ff   <= nxt_ctrl;
            wreg_ff   <= nxt_wreg;
            flags_ff  <= nxt_flags;
            pc_ff     <= nxt_pc;
        end
    end

    // File write-back: the result lands one cycle after the take
    always_comb begin
        nxt_fwe    = 1'b0;
        nxt_fwaddr = fwaddr_ff;
        nxt_fwdata = fwdata_ff;
        if (take && writes_file(INSTR_I)) begin
            nxt_fwe    = 1'b1; // RULE6
            nxt_fwaddr = INSTR_I.file_addr;
            nxt_fwdata = alu_res.data;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            fwe_ff    <= 1'b0;
            fwaddr_ff <= 6'h00;
            fwdata_ff <= 8'h00;
        end else begin
            fwe_ff    <= nxt_fwe;
            fwaddr_ff <= nxt_fwaddr;
            fwdata_ff <= nxt_fwdata;
        end
    end

    // Stack: a taken return pops, a call or interrupt entry pushes
    always_comb begin
        nxt_level = level_ff;
        nxt_stack = stack_ff;
        if (pop) begin
            // Popping an empty stack leaves the level at zero
            if (level_ff != '0) begin
                nxt_level = level_ff - LVL_W'(1); // RULE3
            end
        end else if (PUSH_I && (level_ff < LVL_W'(STACK_DEPTH))) begin
            // A push that meets a return is dropped so the pop stays exact
            nxt_stack[push_idx] = PUSH_ADDR_I;
            nxt_level           = level_ff + LVL_W'(1);
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            level_ff <= '0;
        end else begin
            level_ff <= nxt_level;
        end
    end

    // Entries reset to a known address, so a pop from empty is defined
    genvar g;
    generate
        for (g = 0; g < STACK_DEPTH; g++) begin : g_stack
            always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
                if (!RST_N_I) begin
                    stack_ff[g] <= PC_RST;
                end else begin
                    stack_ff[g] <= nxt_stack[g];
                end
            end
        end
    endgenerate

    // Register read port, data one cycle after the strobe
    always_comb begin
        nxt_rdata = RDATA_RST;
        if (REG_REQ_I.rd) begin
            if (REG_REQ_I.addr == REG_CTRL) begin
                nxt_rdata = ctrl_ff;
            end else if (REG_REQ_I.addr == REG_FLAGS) begin
                nxt_rdata = {4'h0, flags_ff};
            end else if (REG_REQ_I.addr == REG_WREG) begin
                nxt_rdata = wreg_ff;
            end else if (REG_REQ_I.addr == REG_PC_LO) begin
                nxt_rdata = pc_ff[7:0];
            end else if (REG_REQ_I.addr == REG_PC_HI) begin
                nxt_rdata = {6'h00, pc_ff[9:8]};
            end else if (REG_REQ_I.addr == REG_LEVEL) begin
                nxt_rdata = 8'(level_ff);
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rdata_ff <= RDATA_RST;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

endmodule

/* tb/rrse_exec_monitor.sv */
// Purpose: Port-level assertions for the return/rotate/subtract executor
// Assumes: One core clock, asynchronous active-low reset
// Notes:   Operands of the previous cycle are kept in helper flops
`timescale 1ns/1ps
module rrse_exec_monitor
    import rrse_pkg::*;
(
    input  wire logic           CORE_CLK_I,
    input  wire logic           RST_N_I,
    input  wire rrse_bus_req_t  REG_REQ_I,
    input  wire logic           INSTR_VALID_I,
    input  wire rrse_instr_t    INSTR_I,
    input  wire logic           INSTR_READY_O,
    input  wire logic [7:0]     FILE_RDATA_I,
    input  wire logic           FILE_WE_O,
    input  wire logic [5:0]     FILE_WADDR_O,
    input  wire logic [7:0]     FILE_WDATA_O,
    input  wire logic [7:0]     AUX_RDATA_I,
    input  wire logic           FLUSH_O,
    input  wire logic [7:0]     WREG_O,
    input  wire logic [3:0]     FLAGS_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);
    logic       tk;
    logic       qt;
    logic [7:0] frd_ff, wrg_ff, imm_ff, aux_ff;
    logic [5:0] fa_ff;
    logic [3:0] fl_ff;
    logic [8:0] rs, is;
    logic [4:0] rh, ih;
    assign tk = INSTR_VALID_I && INSTR_READY_O;
    // Register-port writes may override flags, so they are left out
    assign qt = !REG_REQ_I.wr;
    assign rs = {1'h0, frd_ff} + {1'h0, ~wrg_ff} + {8'h00, fl_ff[0]};
    assign is = {1'h0, imm_ff} + {1'h0, ~wrg_ff} + {8'h00, fl_ff[0]};
    assign rh = {1'h0, frd_ff[3:0]} + {1'h0, ~wrg_ff[3:0]} + {4'h0, fl_ff[0]};
    assign ih = {1'h0, imm_ff[3:0]} + {1'h0, ~wrg_ff[3:0]} + {4'h0, fl_ff[0]};
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            {frd_ff, wrg_ff, imm_ff, aux_ff, fa_ff, fl_ff} <= '0;
        end else begin
            {frd_ff, wrg_ff, imm_ff, aux_ff} <= {FILE_RDATA_I, WREG_O, INSTR_I.imm, AUX_RDATA_I};
            {fa_ff, fl_ff} <= {INSTR_I.file_addr, FLAGS_O};
        end
    end
    AST_RET_FLUSH: assert property (tk && INSTR_I.op inside {OP_IRQ_RET, OP_SUB_RET}
        |=> FLUSH_O && !INSTR_READY_O ##1 !FLUSH_O) else $error("return flush wrong");
    AST_IRQ_GIE: assert property (tk && INSTR_I.op == OP_IRQ_RET && qt
        |=> FLAGS_O[FLAG_GIE_BIT]) else $error("permit not set on return");
    AST_SUB_KEEP: assert property (tk && INSTR_I.op == OP_SUB_RET && qt
        |=> FLAGS_O == fl_ff) else $error("flags changed on return");
    AST_ROT_L: assert property (tk && INSTR_I.op == OP_ROT_L && !INSTR_I.to_file && qt
        |=> WREG_O == {frd_ff[6:0], fl_ff[0]} && FLAGS_O == {fl_ff[3:1], frd_ff[7]})
        else $error("rotate left wrong");
    AST_ROT_R: assert property (tk && INSTR_I.op == OP_ROT_R && INSTR_I.to_file && qt
        |=> FILE_WE_O && FILE_WADDR_O == fa_ff && FILE_WDATA_O == {fl_ff[0], frd_ff[7:1]}
        && FLAGS_O == {fl_ff[3:1], frd_ff[0]}) else $error("rotate right wrong");
    AST_REG_SBC: assert property (tk && INSTR_I.op == OP_REG_SBC && !INSTR_I.to_file && qt
        |=> WREG_O == rs[7:0] && FLAGS_O == {fl_ff[3], rs[7:0] == 8'h00, rh[4], rs[8]})
        else $error("register subtract wrong");
    AST_SBC_FILE: assert property (tk && INSTR_I.op == OP_REG_SBC && INSTR_I.to_file && qt
        |=> FILE_WE_O && FILE_WDATA_O == rs[7:0] && WREG_O == wrg_ff)
        else $error("subtract target wrong");
    AST_IMM_SBC: assert property (tk && INSTR_I.op == OP_IMM_SBC && qt
        |=> !FILE_WE_O && WREG_O == is[7:0]
        && FLAGS_O == {fl_ff[3], is[7:0] == 8'h00, ih[4], is[8]})
        else $error("immediate subtract wrong");
    AST_AUX_RD: assert property (tk && INSTR_I.op == OP_AUX_RD && qt
        |=> WREG_O == aux_ff && FLAGS_O == fl_ff && !FILE_WE_O) else $error("aux read wrong");
endmodule

/* tb/test_return_rotate_subtract_exec.sv */
// Purpose: Directed bench for the return/rotate/subtract executor
// Assumes: Single 40 MHz clock, every input driven at rising edges
// Notes:   Expected results are computed from the through-carry formulas
`timescale 1ns/1ps
module test_return_rotate_subtract_exec
    import rrse_pkg::*;
;
    logic          clk = 1'h0, rst_n = 1'h0, vld = 1'h0, push = 1'h0;
    rrse_bus_req_t req = '0;
    rrse_instr_t   ins = '0;
    logic [9:0]    paddr = '0, pc;
    logic [7:0]    frd = '0, aux = '0, rd, rdata, wreg, fwd;
    logic [5:0]    fa, fwa;
    logic [3:0]    aidx, flags;
    logic          rdy, fwe, flush;
    int            error_cnt = 0, num_checks = 0;
    always #12.5 clk = ~clk;
    rrse_exec rrse_exec_i (.CORE_CLK_I(clk), .RST_N_I(rst_n), .REG_REQ_I(req),
        .REG_RDATA_O(rdata), .INSTR_VALID_I(vld), .INSTR_I(ins), .INSTR_READY_O(rdy),
        .PUSH_I(push), .PUSH_ADDR_I(paddr), .FILE_ADDR_O(fa), .FILE_RDATA_I(frd),
        .FILE_WE_O(fwe), .FILE_WADDR_O(fwa), .FILE_WDATA_O(fwd), .AUX_IDX_O(aidx),
        .AUX_RDATA_I(aux), .PC_O(pc), .FLUSH_O(flush), .WREG_O(wreg), .FLAGS_O(flags));
    task automatic chk(input string w, input logic [9:0] e, input logic [9:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{a, d, 1'h1, 1'h0};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic rdr(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{a, 8'h00, 1'h0, 1'h1};
        @(posedge clk);
        req <= '0;
        #1 d = rdata;
    endtask
    task automatic pu(input logic [9:0] a);
        @(posedge clk);
        push <= 1'h1;
        paddr <= a;
        @(posedge clk);
        push <= 1'h0;
    endtask
    // Offers one instruction for a single cycle; results are sampled 1 ns after
    task automatic exe(input rrse_op_t op, input logic tf, input logic [7:0] im, f, x);
        @(posedge clk);
        vld <= 1'h1;
        ins <= '{op, 6'h2a, tf, im, 4'hf};
        frd <= f;
        aux <= x;
        @(posedge clk);
        vld <= 1'h0;
        #1;
    endtask
    task automatic t_reset();
        rdr(REG_CTRL, rd);
        chk("ctrl", CTRL_RST, rd);
        wr(3'h7, 8'hff);
        rdr(3'h7, rd);
        chk("unmapped", 8'h00, rd);
        chk("pc", PC_RST, pc);
    endtask
    task automatic t_rot();
        wr(REG_FLAGS, 8'h06);
        exe(OP_ROT_L, DEST_WREG, 8'h00, 8'ha5, 8'h00);
        chk("rotl wreg", 8'h4a, wreg);
        chk("rotl flags", 4'h7, flags);
        exe(OP_ROT_R, DEST_FILE, 8'h00, 8'ha5, 8'h00);
        chk("rotr we", 1'h1, fwe);
        chk("rotr addr", 6'h2a, fwa);
        chk("rotr raddr", 6'h2a, fa);
        chk("rotr data", 8'hd2, fwd);
        chk("rotr wreg", 8'h4a, wreg);
        chk("rotr flags", 4'h7, flags);
    endtask
    task automatic t_sbc();
        logic [7:0] r, a;
        logic [8:0] s;
        logic [4:0] h;
        for (int i = 0; i < 8; i++) begin
            r = i[1] ? 8'h06 : 8'h05;
            a = i[1] ? 8'h05 : 8'h06;
            s = {1'h0, r} + {1'h0, ~a} + 9'(i[0]);
            h = {1'h0, r[3:0]} + {1'h0, ~a[3:0]} + 5'(i[0]);
            wr(REG_WREG, a);
            wr(REG_FLAGS, {7'h00, i[0]});
            exe(i[2] ? OP_IMM_SBC : OP_REG_SBC, i[1], r, r, 8'h00);
            chk("sbc we", !i[2] && i[1], fwe);
            chk("sbc wreg", (i[2] || !i[1]) ? s[7:0] : a, wreg);
            if (!i[2] && i[1]) chk("sbc file", s[7:0], fwd);
            chk("sbc flags", {1'h0, s[7:0] == 8'h00, h[4], s[8]}, flags);
        end
    endtask
    task automatic t_aux();
        wr(REG_FLAGS, 8'h05);
        exe(OP_AUX_RD, DEST_FILE, 8'h00, 8'h00, 8'h3c);
        chk("aux idx", 4'hf, aidx);
        chk("aux wreg", 8'h3c, wreg);
        chk("aux flags", 4'h5, flags);
        chk("aux we", 1'h0, fwe);
        // Disabled core must leave the working register alone
        wr(REG_CTRL, 8'h00);
        exe(OP_AUX_RD, DEST_WREG, 8'h00, 8'h00, 8'h99);
        chk("off ready", 1'h0, rdy);
        chk("off wreg", 8'h3c, wreg);
        wr(REG_CTRL, 8'h01);
    endtask
    task automatic t_ret();
        wr(REG_FLAGS, 8'h00);
        pu(10'h123);
        pu(10'h2ab);
        exe(OP_IRQ_RET, DEST_WREG, 8'h00, 8'h00, 8'h00);
        chk("iret pc", 10'h2ab, pc);
        chk("iret flags", 4'h8, flags);
        chk("iret flush", 1'h1, flush);
        chk("iret ready", 1'h0, rdy);
        @(posedge clk);
        #1;
        chk("flush end", 1'h0, flush);
        chk("ready back", 1'h1, rdy);
        rdr(REG_LEVEL, rd);
        chk("level one", 8'h01, rd);
        wr(REG_FLAGS, 8'h03);
        exe(OP_SUB_RET, DEST_WREG, 8'h00, 8'h00, 8'h00);
        chk("ret pc", 10'h123, pc);
        chk("ret flags", 4'h3, flags);
        chk("ret flush", 1'h1, flush);
        rdr(REG_LEVEL, rd);
        chk("level zero", 8'h00, rd);
    endtask
    // An instruction offered behind a return must be dropped in the flush cycle
    task automatic t_flush();
        wr(REG_WREG, 8'h11);
        pu(10'h155);
        @(posedge clk);
        vld <= 1'h1;
        ins <= '{OP_SUB_RET, 6'h2a, DEST_WREG, 8'h00, 4'hf};
        @(posedge clk);
        ins <= '{OP_AUX_RD, 6'h2a, DEST_WREG, 8'h00, 4'hf};
        aux <= 8'h66;
        @(posedge clk);
        vld <= 1'h0;
        #1;
        chk("stale pc", 10'h155, pc);
        chk("stale wreg", 8'h11, wreg);
        chk("stale ready", 1'h1, rdy);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        t_reset();
        t_rot();
        t_sbc();
        t_aux();
        t_ret();
        t_flush();
        end_of_test();
    end
    initial begin
        repeat (4000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end
endmodule
bind rrse_exec rrse_exec_monitor rrse_exec_monitor_i (.CORE_CLK_I, .RST_N_I, .REG_REQ_I,
    .INSTR_VALID_I, .INSTR_I, .INSTR_READY_O, .FILE_RDATA_I, .FILE_WE_O, .FILE_WADDR_O,
    .FILE_WDATA_O, .AUX_RDATA_I, .FLUSH_O, .WREG_O, .FLAGS_O);
